// file: design/acl_edge.sv
// ============================================================
// Edge detector on a synchronised level.
module acl_edge (
    // Clock and reset.
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // Level in and mode.
    input  wire logic       level,
    input  wire logic [1:0] mode,
    // Single-cycle event out.
    output logic            event_hit
);
    import acl_pkg::*;

    typedef struct packed {
        logic prev;
        logic hit;
    } acl_edge_state_t;

    acl_edge_state_t st;
    acl_edge_state_t next_st;

    // Compare with the value one clock earlier and pick by mode.
    always_comb begin
        next_st.prev = level;
        case (mode) // [R09]
            ACL_MODE_TOGGLE:  next_st.hit = level ^ st.prev; // [R16]
            ACL_MODE_FALLING: next_st.hit = st.prev & ~level;
            ACL_MODE_RISING:  next_st.hit = ~st.prev & level;
            default:          next_st.hit = 1'b0; // Reserved mode raises nothing.
        endcase
    end

    // State register.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign event_hit = st.hit;
endmodule

// file: design/acl_pkg.sv
package acl_pkg;

    // ============================================================
    // Register byte addresses on the APB bus.
    localparam logic [7:0] ACL_ADDR_CTRL_STATUS = 8'h30;
    localparam logic [7:0] ACL_ADDR_CONV_CTRL_B = 8'h34;
    localparam logic [7:0] ACL_ADDR_DIG_IN_OFF  = 8'h38;
    localparam logic [7:0] ACL_ADDR_CONV_CTRL_A = 8'h3c;
    localparam logic [7:0] ACL_ADDR_CONV_MUX    = 8'h40;
    localparam logic [7:0] ACL_ADDR_SYS_CTRL    = 8'h44;

    // ============================================================
    // Field positions in the control and status register.
    localparam int ACL_BIT_DISABLE   = 7;
    localparam int ACL_BIT_BANDGAP   = 6;
    localparam int ACL_BIT_RESULT    = 5;
    localparam int ACL_BIT_INT_FLAG  = 4;
    localparam int ACL_BIT_INT_EN    = 3;
    localparam int ACL_BIT_CAPTURE   = 2;
    localparam int ACL_BIT_MODE_HIGH = 1;
    localparam int ACL_BIT_MODE_LOW  = 0;

    // Field positions in the other registers.
    localparam int ACL_BIT_MUX_EN    = 6;
    localparam int ACL_BIT_NEG_OFF   = 1;
    localparam int ACL_BIT_POS_OFF   = 0;
    localparam int ACL_BIT_CONV_EN   = 7;
    localparam int ACL_BIT_GLOBAL_IE = 0;
    localparam int ACL_BIT_PWR_RED   = 1;
    localparam int ACL_CHAN_W        = 3;

    // Reset value of every control field.
    localparam logic [7:0] ACL_RESET_BYTE = 8'h00;

    // ============================================================
    // Interrupt mode encodings.
    localparam logic [1:0] ACL_MODE_TOGGLE  = 2'h0;
    localparam logic [1:0] ACL_MODE_RSVD    = 2'h1;
    localparam logic [1:0] ACL_MODE_FALLING = 2'h2;
    localparam logic [1:0] ACL_MODE_RISING  = 2'h3;

    // ============================================================
    // Analog side controls, grouped for the comparator macro.
    typedef struct packed {
        logic                power_down;
        logic                pos_bandgap;
        logic                neg_use_channel;
        logic [ACL_CHAN_W-1:0] channel;
    } acl_analog_ctrl_t;

    // APB request and answer.
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } acl_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } acl_apb_rsp_t;

endpackage

// file: design/acl_sync.sv
// ============================================================
// Two flip-flop synchroniser for one level.
module acl_sync (
    // Clock and reset.
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // Data.
    input  wire logic din,
    output logic      dout
);
    import acl_pkg::*;

    typedef struct packed {
        logic first;
        logic second;
    } acl_sync_state_t;

    acl_sync_state_t st;
    acl_sync_state_t next_st;

    // The first stage feeds only the second stage.
    always_comb begin
        next_st.first  = din;
        next_st.second = st.first;
    end

    // State register.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign dout = st.second;
endmodule

// file: design/acl_top.sv
// What this block does
// R01 - The result is high when the chosen positive input is above the chosen negative input.
// R02 - With mux enable set and the converter off, the channel select picks the negative input.
// R03 - The bandgap select bit puts the reference on the positive input instead of the pin.
// R04 - The disable bit switches comparator power off at any time and back on when cleared.
// R05 - The raw output is synchronised, adding one to two clocks, before it reads as result.
// R06 - The flag is set on the chosen edge type whether or not the interrupt is enabled.
// R07 - The interrupt is requested only with flag, enable and global enable all set.
// R08 - The flag clears when its vector runs or on a write of one; zero leaves it.
// R09 - Mode 00 is toggle, 01 reserved, 10 falling edge and 11 rising edge.
// R10 - The capture route bit feeds the result to the timer capture input, else nothing.
// R11 - Software clears the interrupt enable before changing the interrupt mode.
// R12 - Software clears the interrupt enable before changing the disable bit.
// R13 - A pin's input-off bit disables its digital buffer and forces its port bit to zero.
// R14 - Software keeps converter power reduction at zero while the mux serves the comparator.
// R15 - The converter enable bit shows converter power and gates mux use by the comparator.
// R16 - Edges are found by comparing the result with its value one clock earlier.
module acl_top (
    // Clock and reset.
    input  wire logic                      clk_sys,
    input  wire logic                      arst_n,
    // APB slave.
    input  wire acl_pkg::acl_apb_req_t     apb_req,
    output acl_pkg::acl_apb_rsp_t          apb_rsp,
    // Analog comparator macro.
    input  wire logic                      comparator_raw,
    output acl_pkg::acl_analog_ctrl_t      analog_ctrl,
    // Pins and port input bits.
    input  wire logic                      positive_pin,
    input  wire logic                      negative_pin,
    output logic                           positive_pin_port_bit,
    output logic                           negative_pin_port_bit,
    output logic                           positive_pin_input_off,
    output logic                           negative_pin_input_off,
    // Interrupt and timer.
    input  wire logic                      int_vector_ack,
    output logic                           comparator_irq,
    output logic                           capture_input,
    output logic                           converter_enable
);
    import acl_pkg::*;

    // ============================================================
    // Reset release.
    logic [1:0] rst_pipe;
    logic       rst_n;

    // Release the asynchronous reset through two flip-flops.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    // ============================================================
    // Block state.
    typedef struct packed {
        logic                  comparator_disable;
        logic                  bandgap_select;
        logic                  comparator_int_flag;
        logic                  comparator_int_enable;
        logic                  capture_route_enable;
        logic [1:0]            int_mode;
        logic                  neg_input_mux_enable;
        logic                  positive_pin_input_off;
        logic                  negative_pin_input_off;
        logic                  converter_enable;
        logic [ACL_CHAN_W-1:0] channel_select;
        logic                  global_int_enable;
        logic                  converter_power_reduce;
        logic [31:0]           rdata;
        logic                  pos_port;
        logic                  neg_port;
    } acl_state_t;

    acl_state_t st;
    acl_state_t next_st;

    logic comparator_result;
    logic edge_event;
    logic pos_pin_sync;
    logic neg_pin_sync;
    logic wr_strobe;
    logic rd_strobe;

    // ============================================================
    // Synchronisers and edge detection.
    acl_sync u_sync_result (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .din     (comparator_raw),
        .dout    (comparator_result)
    ); // [R05]

    acl_sync u_sync_pos (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .din     (positive_pin),
        .dout    (pos_pin_sync)
    );

    acl_sync u_sync_neg (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .din     (negative_pin),
        .dout    (neg_pin_sync)
    );

    acl_edge u_edge (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .level     (comparator_result),
        .mode      (st.int_mode),
        .event_hit (edge_event)
    ); // [R16]

    // ============================================================
    // Bus strobes: every access completes in its first access cycle.
    assign wr_strobe = apb_req.psel & apb_req.penable & apb_req.pwrite;
    assign rd_strobe = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;

    // Byte of the control and status register as software reads it.
    function automatic logic [7:0] acl_status_byte(input acl_state_t s, input logic res);
        logic [7:0] b;
        b                    = ACL_RESET_BYTE;
        b[ACL_BIT_DISABLE]   = s.comparator_disable;
        b[ACL_BIT_BANDGAP]   = s.bandgap_select;
        b[ACL_BIT_RESULT]    = res; // [R05]
        b[ACL_BIT_INT_FLAG]  = s.comparator_int_flag;
        b[ACL_BIT_INT_EN]    = s.comparator_int_enable;
        b[ACL_BIT_CAPTURE]   = s.capture_route_enable;
        b[ACL_BIT_MODE_HIGH] = s.int_mode[1];
        b[ACL_BIT_MODE_LOW]  = s.int_mode[0];
        return b;
    endfunction

    // Register writes, flag handling, read data capture and port bits.
    always_comb begin
        logic [7:0] wb;
        logic [7:0] rb;
        logic       clr;
        wb      = apb_req.pwdata[7:0];
        rb      = ACL_RESET_BYTE;
        clr     = 1'b0;
        next_st = st;

        // Writes take effect at the access edge.
        if (wr_strobe) begin
            case (apb_req.paddr)
                ACL_ADDR_CTRL_STATUS: begin
                    next_st.comparator_disable    = wb[ACL_BIT_DISABLE]; // [R04]
                    next_st.bandgap_select        = wb[ACL_BIT_BANDGAP]; // [R03]
                    next_st.comparator_int_enable = wb[ACL_BIT_INT_EN];
                    next_st.capture_route_enable  = wb[ACL_BIT_CAPTURE];
                    next_st.int_mode = {wb[ACL_BIT_MODE_HIGH], wb[ACL_BIT_MODE_LOW]};
                    clr = wb[ACL_BIT_INT_FLAG]; // [R08]
                end
                ACL_ADDR_CONV_CTRL_B: next_st.neg_input_mux_enable = wb[ACL_BIT_MUX_EN];
                ACL_ADDR_DIG_IN_OFF: begin
                    next_st.positive_pin_input_off = wb[ACL_BIT_POS_OFF];
                    next_st.negative_pin_input_off = wb[ACL_BIT_NEG_OFF];
                end
                ACL_ADDR_CONV_CTRL_A: next_st.converter_enable = wb[ACL_BIT_CONV_EN]; // [R15]
                ACL_ADDR_CONV_MUX:    next_st.channel_select = wb[ACL_CHAN_W-1:0];
                ACL_ADDR_SYS_CTRL: begin
                    next_st.global_int_enable      = wb[ACL_BIT_GLOBAL_IE];
                    next_st.converter_power_reduce = wb[ACL_BIT_PWR_RED];
                end
                default: ;
            endcase
        end

        // Vector execution also clears; a new edge in the same cycle wins.
        if (int_vector_ack) begin
            clr = 1'b1; // [R08]
        end
        if (edge_event) begin
            next_st.comparator_int_flag = 1'b1; // [R06]
        end else if (clr) begin
            next_st.comparator_int_flag = 1'b0; // [R08]
        end

        // Read data is captured in the setup cycle and presented in access.
        case (apb_req.paddr)
            ACL_ADDR_CTRL_STATUS: rb = acl_status_byte(st, comparator_result);
            ACL_ADDR_CONV_CTRL_B: rb[ACL_BIT_MUX_EN] = st.neg_input_mux_enable;
            ACL_ADDR_DIG_IN_OFF: begin
                rb[ACL_BIT_POS_OFF] = st.positive_pin_input_off;
                rb[ACL_BIT_NEG_OFF] = st.negative_pin_input_off;
            end
            ACL_ADDR_CONV_CTRL_A: rb[ACL_BIT_CONV_EN] = st.converter_enable;
            ACL_ADDR_CONV_MUX:    rb[ACL_CHAN_W-1:0] = st.channel_select;
            ACL_ADDR_SYS_CTRL: begin
                rb[ACL_BIT_GLOBAL_IE] = st.global_int_enable;
                rb[ACL_BIT_PWR_RED]   = st.converter_power_reduce;
            end
            default: rb = ACL_RESET_BYTE;
        endcase
        if (rd_strobe) begin
            next_st.rdata = {24'h000000, rb};
        end

        // Port input bits read zero while the buffer is disabled.
        next_st.pos_port = pos_pin_sync & ~st.positive_pin_input_off; // [R13]
        next_st.neg_port = neg_pin_sync & ~st.negative_pin_input_off; // [R13]
    end

    // State register.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ============================================================
    // Outputs.

    // Bus answer: zero wait states; unmapped addresses read zero, no error.
    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.pslverr = 1'b0;
    assign apb_rsp.prdata  = st.rdata;

    // Analog controls: the macro drives comparator_raw high when plus exceeds minus.
    assign analog_ctrl.power_down      = st.comparator_disable; // [R04] [R01]
    assign analog_ctrl.pos_bandgap     = st.bandgap_select; // [R03]
    assign analog_ctrl.neg_use_channel = st.neg_input_mux_enable
                                         & ~st.converter_enable; // [R02] [R15]
    assign analog_ctrl.channel         = st.channel_select; // [R02]

    // Interrupt request and capture route.
    assign comparator_irq = st.comparator_int_flag & st.comparator_int_enable
                            & st.global_int_enable; // [R07]
    assign capture_input  = st.capture_route_enable & comparator_result; // [R10]

    assign positive_pin_input_off = st.positive_pin_input_off; // [R13]
    assign negative_pin_input_off = st.negative_pin_input_off; // [R13]
    assign positive_pin_port_bit  = st.pos_port;
    assign negative_pin_port_bit  = st.neg_port;
    assign converter_enable       = st.converter_enable;
endmodule

// file: sim/acl_monitor.sv
// ============================================================
// Port checker for the comparator control block.
module acl_monitor (
    // Clock and reset.
    input wire logic                      clk_sys,
    input wire logic                      arst_n,
    // Observed ports.
    input wire acl_pkg::acl_apb_req_t     apb_req,
    input wire acl_pkg::acl_apb_rsp_t     apb_rsp,
    input wire logic                      comparator_raw,
    input wire acl_pkg::acl_analog_ctrl_t analog_ctrl,
    input wire logic                      positive_pin_port_bit,
    input wire logic                      negative_pin_input_off,
    input wire logic                      positive_pin_input_off,
    input wire logic                      capture_input,
    input wire logic                      converter_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    import acl_pkg::*;

    logic       wr;
    logic [7:0] a;

    // Completed write and its address.
    assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
    assign a  = apb_req.paddr;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    // ============================================================
    // Assertions.
    bus_ready_a: assert property (apb_rsp.pready && !apb_rsp.pslverr)
        else $error("bus answer not ready or error");
    power_write_a: assert property (wr && a == ACL_ADDR_CTRL_STATUS |=>
        analog_ctrl.power_down == $past(apb_req.pwdata[ACL_BIT_DISABLE])
        && analog_ctrl.pos_bandgap == $past(apb_req.pwdata[ACL_BIT_BANDGAP]))
        else $error("power or bandgap control not written");
    power_hold_a: assert property (!(wr && a == ACL_ADDR_CTRL_STATUS) |=>
        $stable(analog_ctrl.power_down)) else $error("power control changed alone");
    chan_write_a: assert property (wr && a == ACL_ADDR_CONV_MUX |=>
        analog_ctrl.channel == $past(apb_req.pwdata[2:0])) else $error("channel not written");
    mux_gate_a: assert property (analog_ctrl.neg_use_channel |-> !converter_enable)
        else $error("mux used while converter on");
    conv_write_a: assert property (wr && a == ACL_ADDR_CONV_CTRL_A |=>
        converter_enable == $past(apb_req.pwdata[7])) else $error("converter enable wrong");
    dig_write_a: assert property (wr && a == ACL_ADDR_DIG_IN_OFF |=>
        negative_pin_input_off == $past(apb_req.pwdata[1])) else $error("input off wrong");
    pos_off_a: assert property ($past(positive_pin_input_off) && positive_pin_input_off
        |-> !positive_pin_port_bit) else $error("port bit not forced low");
    capture_sync_a: assert property (capture_input |-> $past(comparator_raw, 2))
        else $error("capture input not the synced result");

    // Main scenarios reached.
    cover property (capture_input);
    cover property (analog_ctrl.neg_use_channel);
    cover property ($rose(positive_pin_input_off));
endmodule

bind acl_top acl_monitor u_acl_monitor (.clk_sys(clk_sys), .arst_n(arst_n),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .comparator_raw(comparator_raw),
    .analog_ctrl(analog_ctrl), .positive_pin_port_bit(positive_pin_port_bit),
    .negative_pin_input_off(negative_pin_input_off),
    .positive_pin_input_off(positive_pin_input_off), .capture_input(capture_input),
    .converter_enable(converter_enable));

// file: sim/test_comparator_control_logic.sv
// ============================================================
// Self-checking bench for the comparator control block.
module test_comparator_control_logic;
    timeunit 1ns;
    timeprecision 1ps;
    import acl_pkg::*;

    logic             clk_sys, arst_n, raw, ppin, npin, ack;
    logic             pbit, nbit, poff, noff, irq, cap, conv;
    acl_apb_req_t     req;
    acl_apb_rsp_t     rsp;
    acl_analog_ctrl_t actl;
    logic [31:0]      rd;
    int               num_errors, comparisons, cycles;

    acl_top u_acl_top (.clk_sys(clk_sys), .arst_n(arst_n), .apb_req(req), .apb_rsp(rsp),
        .comparator_raw(raw), .analog_ctrl(actl), .positive_pin(ppin), .negative_pin(npin),
        .positive_pin_port_bit(pbit), .negative_pin_port_bit(nbit),
        .positive_pin_input_off(poff), .negative_pin_input_off(noff),
        .int_vector_ack(ack), .comparator_irq(irq), .capture_input(cap),
        .converter_enable(conv));

    // 20 MHz clock.
    always #25 clk_sys = ~clk_sys;

    // Cuts a hang short.
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            test_done();
        end
    end

    // ============================================================
    // Shared tasks.
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Lets edges pass, then samples mid-cycle.
    task wait_clk(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    // One APB transfer; read data lands in rd. Only the bench timeout ends a stuck wait.
    task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        req <= '{1'b1, 1'b0, w, a, {24'h0, d}};
        @(posedge clk_sys);
        req.penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        req <= '0;
    endtask

    task set_raw(input logic v);
        @(posedge clk_sys);
        raw <= v;
    endtask

    // ============================================================
    // Scenarios.
    task t_regs();
        logic [7:0] adr [7];
        adr = '{ACL_ADDR_CTRL_STATUS, ACL_ADDR_CONV_CTRL_B, ACL_ADDR_DIG_IN_OFF,
                ACL_ADDR_CONV_CTRL_A, ACL_ADDR_CONV_MUX, ACL_ADDR_SYS_CTRL, 8'h00};
        apb(1'b1, 8'h00, 8'hff);
        foreach (adr[i]) begin
            apb(1'b0, adr[i], 8'h00);
            check(rd, {24'h0, ACL_RESET_BYTE});
        end
    endtask

    task t_analog();
        apb(1'b1, ACL_ADDR_CTRL_STATUS, 8'hc0);
        apb(1'b0, ACL_ADDR_CTRL_STATUS, 8'h00);
        check({actl.power_down, actl.pos_bandgap, rd[7:0]}, 10'h3c0);
        apb(1'b1, ACL_ADDR_CTRL_STATUS, 8'h40);
        wait_clk(1);
        check({actl.power_down, actl.pos_bandgap}, 2'b01);
    endtask

    task t_mux();
        apb(1'b1, ACL_ADDR_CONV_CTRL_B, 8'h40);
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, ACL_ADDR_CONV_MUX, c[7:0]);
            wait_clk(1);
            check({actl.neg_use_channel, actl.channel}, {1'b1, c[2:0]});
        end
        apb(1'b1, ACL_ADDR_CONV_CTRL_A, 8'h80);
        wait_clk(1);
        check({actl.neg_use_channel, conv}, 2'b01);
        apb(1'b1, ACL_ADDR_CONV_CTRL_A, 8'h00);
        apb(1'b1, ACL_ADDR_CONV_CTRL_B, 8'h00);
        wait_clk(1);
        check({actl.neg_use_channel, conv}, 2'b00);
    endtask

    task t_pins();
        @(posedge clk_sys);
        ppin <= 1'b1;
        npin <= 1'b1;
        wait_clk(5);
        check({pbit, nbit}, 2'b11);
        apb(1'b1, ACL_ADDR_DIG_IN_OFF, 8'h01);
        wait_clk(1);
        check({poff, noff, pbit, nbit}, 4'b1001);
        apb(1'b1, ACL_ADDR_DIG_IN_OFF, 8'h02);
        wait_clk(1);
        check({poff, noff, pbit, nbit}, 4'b0110);
    endtask

    // Interrupt enable stays clear while the mode changes; comparator power stays on.
    task t_edges();
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, ACL_ADDR_CTRL_STATUS, {6'h04, m[1:0]});
            set_raw(1'b1);
            wait_clk(5);
            apb(1'b0, ACL_ADDR_CTRL_STATUS, 8'h00);
            check(rd, {26'h0, 1'b1, m == 0 || m == 3, 2'h0, m[1:0]});
            apb(1'b1, ACL_ADDR_CTRL_STATUS, {6'h04, m[1:0]});
            set_raw(1'b0);
            wait_clk(5);
            apb(1'b0, ACL_ADDR_CTRL_STATUS, 8'h00);
            check(rd, {26'h0, 1'b0, m == 0 || m == 2, 2'h0, m[1:0]});
        end
    endtask

    // Power reduction bit kept at zero throughout.
    task t_irq();
        apb(1'b1, ACL_ADDR_SYS_CTRL, 8'h01);
        apb(1'b1, ACL_ADDR_CTRL_STATUS, 8'h18);
        set_raw(1'b1);
        wait_clk(5);
        check(irq, 1'b1);
        @(posedge clk_sys);
        ack <= 1'b1;
        @(posedge clk_sys);
        ack <= 1'b0;
        wait_clk(1);
        check(irq, 1'b0);
        set_raw(1'b0);
        wait_clk(5);
        apb(1'b1, ACL_ADDR_SYS_CTRL, 8'h00);
        wait_clk(1);
        check(irq, 1'b0);
        apb(1'b1, ACL_ADDR_SYS_CTRL, 8'h01);
        apb(1'b1, ACL_ADDR_CTRL_STATUS, 8'h04);
        apb(1'b0, ACL_ADDR_CTRL_STATUS, 8'h00);
        check({irq, rd[7:0]}, 9'h014);
        set_raw(1'b1);
        wait_clk(3);
        check(cap, 1'b1);
        apb(1'b1, ACL_ADDR_CTRL_STATUS, 8'h10);
        wait_clk(1);
        check(cap, 1'b0);
    endtask

    task test_done();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        clk_sys = 1'b0;
        arst_n = 1'b0;
        raw = 1'b0;
        ppin = 1'b0;
        npin = 1'b0;
        ack = 1'b0;
        req = '0;
        num_errors = 0;
        comparisons = 0;
        cycles = 0;
        repeat (3) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_regs();
        t_analog();
        t_mux();
        t_pins();
        t_edges();
        t_irq();
        test_done();
    end
endmodule
